// File: hdl/msfs_top.sv
// multi-speed frequency select: apb register file, terminal routing, priority
// What this block does
// [RULE_01] single high/middle/low picks preset 1, 2, 3
// [RULE_02] presets take 0-400Hz; 4-15 also 9999
// [RULE_03] several plain selects: lowest-ranked select wins when their combo preset (4-7) holds 9999
// [RULE_04] speeds 4-15 decoded from all four selects
// [RULE_05] after reset speeds 4-15 are not selected
// [RULE_06] extend alone: preset 8, or low preset while 8 holds 9999
// [RULE_07] terminal code 8 routes the extend select
// [RULE_08] codes 0/1/2 route low, middle, high select
// [RULE_09] priority: jog, multi, current, then voltage
// [RULE_10] multi-speed only in operation modes 3, 4
// [RULE_11] presets 4-15 unranked; one combination, one preset
// [RULE_12] remote function nonzero disables multi-speed
// [RULE_13] presets writable while running, any mode
// [RULE_14] preset writes accepted in panel and external
// [RULE_15] presets 4-15 writable only when extdisp zero
// [RULE_16] remote 1-3: inputs become up, down, clear
// [RULE_17] pair and triple combos map speeds 4-7
// [RULE_18] nothing usable: no multi command, lower sources
// assumes terminal inputs and analog commands are synchronous to pclk
`timescale 1ns/1ps

module msfs_top
    import msfs_pkg::*;
#(
    parameter int NTERM = 5
)
(
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic [APB_AW-1:0]       paddr,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [APB_DW-1:0]       pwdata,
    output logic      [APB_DW-1:0]       prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic [NTERM-1:0]        term_in,
    input  wire logic [FREQ_W-1:0]       jog_freq,
    input  wire logic                    cur_valid,
    input  wire logic [FREQ_W-1:0]       cur_freq,
    input  wire logic                    volt_valid,
    input  wire logic [FREQ_W-1:0]       volt_freq,
    output logic      [FREQ_W-1:0]       freq_cmd,
    output msfs_pkg::msfs_src_t          freq_src,
    output logic                         cmd_valid,
    output logic      [3:0]              speed_sel,
    output logic                         remote_up,
    output logic                         remote_down,
    output logic                         remote_clear
);

    // ==============================================
    // state of the block, one packed record
    typedef struct packed {
        logic [NPRESET-1:0][FREQ_W-1:0] preset;
        logic [MODE_W-1:0]              op_mode;
        logic [REMOTE_W-1:0]            remote;
        logic [3:0]                     ext_disp;
        logic [NTERM-1:0][FN_W-1:0]     term_fn;
        logic                           pready;
        logic                           pslverr;
        logic [APB_DW-1:0]              prdata;
        logic [FREQ_W-1:0]              freq;
        msfs_src_t                      src;
        logic                           valid;
        logic [3:0]                     speed;
        logic                           up;
        logic                           down;
        logic                           clear;
    } msfs_state_t;

    msfs_state_t q;
    msfs_state_t d;

    // ==============================================
    // helper functions

    // any terminal whose function code matches and whose contact is closed
    function automatic logic routed(input logic [NTERM-1:0][FN_W-1:0] fn,
                                    input logic [NTERM-1:0] pins,
                                    input logic [FN_W-1:0] code);
        logic hit;
        hit = 1'b0;
        for (int i = 0; i < NTERM; i++) begin
            if (fn[i] == code && pins[i]) begin
                hit = 1'b1;
            end
        end
        routed = hit;
    endfunction

    // register word index of a preset address, 0 based
    function automatic logic [3:0] preset_idx(input logic [APB_AW-1:0] a);
        preset_idx = a[5:2];
    endfunction

    // terminal index of a terminal-select address
    function automatic logic [APB_AW-1:0] term_idx(input logic [APB_AW-1:0] a);
        term_idx = (a - OFF_TERM) >> 2;
    endfunction

    // is the address mapped at all
    function automatic logic mapped(input logic [APB_AW-1:0] a);
        logic ok;
        ok = 1'b0;
        if (a[1:0] == 2'b00) begin
            if (a <= OFF_PRESET_LAST) begin
                ok = 1'b1;
            end else if (a == OFF_MODE || a == OFF_REMOTE ||
                         a == OFF_EXTDISP || a == OFF_STATUS) begin
                ok = 1'b1;
            end else if (a >= OFF_TERM && term_idx(a) < APB_AW'(NTERM)) begin
                ok = 1'b1;
            end
        end
        mapped = ok;
    endfunction

    // legality of a write: range checks and the extended-display lock
    function automatic logic write_ok(input logic [APB_AW-1:0] a,
                                      input logic [APB_DW-1:0] w,
                                      input logic [3:0] ext_disp);
        logic ok;
        ok = mapped(a) && (a != OFF_STATUS);
        if (a <= OFF_PRESET_LAST) begin
            if (preset_idx(a) < 4'h3) begin
                ok = ok && (w <= APB_DW'(FREQ_MAX));            // [RULE_02]
            end else begin
                ok = ok && (ext_disp == 4'h0) &&                // [RULE_15]
                     ((w <= APB_DW'(FREQ_MAX)) ||
                      (w == APB_DW'(NOT_SEL)));                 // [RULE_02]
            end
        end
        write_ok = ok;
    endfunction

    // ==============================================
    // routed select signals
    logic high_speed_select;
    logic middle_speed_select;
    logic low_speed_select;
    logic speed_extend_select;
    logic jog_select;
    logic [3:0] dec_speed;

    // terminal codes steer which contact drives which function
    always_comb begin
        low_speed_select    = routed(q.term_fn, term_in, FN_LOW);  // [RULE_08]
        middle_speed_select = routed(q.term_fn, term_in, FN_MID);  // [RULE_08]
        high_speed_select   = routed(q.term_fn, term_in, FN_HIGH); // [RULE_08]
        speed_extend_select = routed(q.term_fn, term_in, FN_EXT);  // [RULE_07]
        jog_select          = routed(q.term_fn, term_in, FN_JOG);
    end

    msfs_speed_decode u_decode (
        .high_speed_select   (high_speed_select),
        .middle_speed_select (middle_speed_select),
        .low_speed_select    (low_speed_select),
        .speed_extend_select (speed_extend_select),
        .preset              (q.preset),
        .speed               (dec_speed)
    );

    // ==============================================
    // next-state logic
    logic                multi_on;
    logic                setup;
    logic                commit;
    logic [APB_DW-1:0]   rd;
    logic [APB_AW-1:0]   ti;

    always_comb begin
        d  = q;
        rd = '0;
        ti = term_idx(paddr);

        // apb: answer one cycle after setup, no further wait states
        setup  = psel && !penable && !q.pready;
        commit = psel && penable && q.pready;
        d.pready  = setup;
        if (setup) begin
            d.pslverr = pwrite ? !write_ok(paddr, pwdata, q.ext_disp)
                               : !mapped(paddr);
        end else if (!psel) begin
            d.pslverr = 1'b0;
        end

        // read data is captured at setup so it is steady through access
        if (paddr <= OFF_PRESET_LAST) begin
            rd[FREQ_W-1:0] = q.preset[preset_idx(paddr)];
        end else if (paddr == OFF_MODE) begin
            rd[MODE_W-1:0] = q.op_mode;
        end else if (paddr == OFF_REMOTE) begin
            rd[REMOTE_W-1:0] = q.remote;
        end else if (paddr == OFF_EXTDISP) begin
            rd[3:0] = q.ext_disp;
        end else if (paddr == OFF_STATUS) begin
            rd[ST_SPEED_LSB +: 4]      = q.speed;
            rd[ST_SRC_LSB +: 3]        = q.src;
            rd[ST_VALID_BIT]           = q.valid;
            rd[ST_FREQ_LSB +: FREQ_W]  = q.freq;
        end else if (ti < APB_AW'(NTERM)) begin
            rd[FN_W-1:0] = q.term_fn[ti[2:0]];
        end
        if (setup && !pwrite) begin
            d.prdata = mapped(paddr) ? rd : '0;
        end

        // writes land only at the completing edge, and only when legal;
        // no run or mode interlock guards the presets
        if (commit && pwrite && !q.pslverr) begin              // [RULE_13] [RULE_14]
            if (paddr <= OFF_PRESET_LAST) begin
                d.preset[preset_idx(paddr)] = pwdata[FREQ_W-1:0];
            end else if (paddr == OFF_MODE) begin
                d.op_mode = pwdata[MODE_W-1:0];
            end else if (paddr == OFF_REMOTE) begin
                d.remote = pwdata[REMOTE_W-1:0];
            end else if (paddr == OFF_EXTDISP) begin
                d.ext_disp = pwdata[3:0];
            end else begin
                d.term_fn[ti[2:0]] = pwdata[FN_W-1:0];
            end
        end

        // multi-speed needs external or combined mode and no remote use
        multi_on = ((q.op_mode == MODE_EXT) || (q.op_mode == MODE_COMB)) // [RULE_10]
                   && (q.remote == REMOTE_RST);                         // [RULE_12]

        // remote setting reuses the same three contacts
        d.up    = (q.remote != REMOTE_RST) && high_speed_select;    // [RULE_16]
        d.down  = (q.remote != REMOTE_RST) && middle_speed_select;  // [RULE_16]
        d.clear = (q.remote != REMOTE_RST) && low_speed_select;     // [RULE_16]

        // fixed priority between external frequency sources
        d.speed = multi_on ? dec_speed : 4'h0;
        if (jog_select) begin                                  // [RULE_09]
            d.src   = SRC_JOG;
            d.freq  = jog_freq;
            d.valid = 1'b1;
        end else if (multi_on && dec_speed != 4'h0) begin      // [RULE_09]
            d.src   = SRC_MULTI;
            d.freq  = q.preset[dec_speed - 4'h1];
            d.valid = 1'b1;
        end else if (cur_valid) begin                          // [RULE_18]
            d.src   = SRC_CURRENT;
            d.freq  = cur_freq;
            d.valid = 1'b1;
        end else if (volt_valid) begin                         // [RULE_09]
            d.src   = SRC_VOLTAGE;
            d.freq  = volt_freq;
            d.valid = 1'b1;
        end else begin
            d.src   = SRC_NONE;
            d.freq  = '0;
            d.valid = 1'b0;
        end
    end

    // ==============================================
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q          <= '0;
            q.preset   <= {{(NPRESET-3){NOT_SEL}},            // [RULE_05]
                           LOW_RST, MID_RST, HIGH_RST};       // [RULE_01]
            q.op_mode  <= MODE_RST;
            q.remote   <= REMOTE_RST;
            q.ext_disp <= EXTDISP_RST;
            q.term_fn  <= TERM_RST[NTERM*FN_W-1:0];
            q.src      <= SRC_NONE;
        end else begin
            q <= d;
        end
    end

    // ==============================================
    // outputs straight from the state register
    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign freq_cmd     = q.freq;
    assign freq_src     = q.src;
    assign cmd_valid    = q.valid;
    assign speed_sel    = q.speed;
    assign remote_up    = q.up;
    assign remote_down  = q.down;
    assign remote_clear = q.clear;

endmodule

// File: hdl/msfs_pkg.sv
// constants, field layouts and types of the multi-speed frequency select block
// assumes an apb master on a single 40 MHz clock; no timing counts are needed
package msfs_pkg;

    // ==============================================
    // bus and data widths
    localparam int          APB_AW      = 8;
    localparam int          APB_DW      = 32;
    localparam int          FREQ_W      = 14;     // preset unit is 0.1 Hz
    localparam int          NPRESET     = 15;
    localparam int          FN_W        = 4;

    // ==============================================
    // preset values (0.1 Hz units)
    localparam logic [13:0] FREQ_MAX    = 14'h0fa0; // 400.0 Hz
    localparam logic [13:0] NOT_SEL     = 14'h270f; // 9999: speed not selected
    localparam logic [13:0] HIGH_RST    = 14'h0258; // 60.0 Hz
    localparam logic [13:0] MID_RST     = 14'h012c; // 30.0 Hz
    localparam logic [13:0] LOW_RST     = 14'h0064; // 10.0 Hz

    // ==============================================
    // register byte offsets
    localparam logic [7:0]  OFF_PRESET  = 8'h00;  // presets 1..15, one word each
    localparam logic [7:0]  OFF_PRESET_LAST = 8'h38;
    localparam logic [7:0]  OFF_MODE    = 8'h40;
    localparam logic [7:0]  OFF_REMOTE  = 8'h44;
    localparam logic [7:0]  OFF_EXTDISP = 8'h48;
    localparam logic [7:0]  OFF_TERM    = 8'h4c;  // one word per terminal
    localparam logic [7:0]  OFF_STATUS  = 8'h60;

    // ==============================================
    // field positions and reset values
    localparam int          MODE_W      = 3;
    localparam int          REMOTE_W    = 2;
    localparam logic [2:0]  MODE_RST    = 3'h0;
    localparam logic [2:0]  MODE_EXT    = 3'h3;
    localparam logic [2:0]  MODE_COMB   = 3'h4;
    localparam logic [1:0]  REMOTE_RST  = 2'h0;
    localparam logic [3:0]  EXTDISP_RST = 4'h0;
    localparam int          ST_SPEED_LSB = 0;   // status [3:0] chosen speed
    localparam int          ST_SRC_LSB   = 4;   // status [6:4] command source
    localparam int          ST_VALID_BIT = 8;   // status [8] command valid
    localparam int          ST_FREQ_LSB  = 16;  // status [29:16] frequency

    // ==============================================
    // terminal function codes
    localparam logic [3:0]  FN_LOW      = 4'h0;
    localparam logic [3:0]  FN_MID      = 4'h1;
    localparam logic [3:0]  FN_HIGH     = 4'h2;
    localparam logic [3:0]  FN_JOG      = 4'h5;
    localparam logic [3:0]  FN_EXT      = 4'h8;
    localparam logic [3:0]  FN_NONE     = 4'hf;
    localparam logic [19:0] TERM_RST    = {FN_NONE, FN_JOG, FN_HIGH, FN_MID, FN_LOW};

    // command source of the frequency output
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_JOG,
        SRC_MULTI,
        SRC_CURRENT,
        SRC_VOLTAGE
    } msfs_src_t;

endpackage

// File: hdl/msfs_speed_decode.sv
// speed decoder: maps the four select levels and stored presets to one speed
// assumes presets 1..3 never hold the not-selected value
`timescale 1ns/1ps

module msfs_speed_decode
    import msfs_pkg::*;
(
    input  wire logic                             high_speed_select,
    input  wire logic                             middle_speed_select,
    input  wire logic                             low_speed_select,
    input  wire logic                             speed_extend_select,
    input  wire logic [NPRESET-1:0][FREQ_W-1:0]   preset,
    output logic      [3:0]                       speed
);

    // ==============================================
    // helpers
    function automatic logic [3:0] combo(input logic [2:0] c);
        unique case (c)
            3'b100:  combo = 4'h1;
            3'b010:  combo = 4'h2;
            3'b001:  combo = 4'h3;
            3'b011:  combo = 4'h4;   // [RULE_17]
            3'b101:  combo = 4'h5;   // [RULE_17]
            3'b110:  combo = 4'h6;   // [RULE_17]
            3'b111:  combo = 4'h7;   // [RULE_17]
            default: combo = 4'h0;
        endcase
    endfunction

    function automatic logic usable(input logic [3:0] s,
                                    input logic [NPRESET-1:0][FREQ_W-1:0] p);
        usable = (s != 4'h0) && (p[s - 4'h1] != NOT_SEL);
    endfunction

    // ==============================================
    // fallback chain: extended combo, then plain combo, then lowest select
    logic [2:0] sel3;
    logic [3:0] first;
    logic [3:0] plain;
    logic [3:0] lowest;
    always_comb begin
        sel3   = {high_speed_select, middle_speed_select, low_speed_select};
        plain  = combo(sel3);
        // extend alone falls back to the low preset
        if (sel3 == 3'b000) begin
            plain = 4'h3;                                  // [RULE_06]
        end
        first  = speed_extend_select ? {1'b1, sel3} : plain; // [RULE_04] [RULE_11]
        lowest = low_speed_select    ? 4'h3 :
                 middle_speed_select ? 4'h2 :
                 high_speed_select   ? 4'h1 : 4'h0;        // [RULE_03]
        if (!speed_extend_select && sel3 == 3'b000) begin
            speed = 4'h0;                                  // [RULE_18]
        end else if (usable(first, preset)) begin
            speed = first;                                 // [RULE_01]
        end else if (usable(plain, preset)) begin
            speed = plain;
        end else if (usable(lowest, preset)) begin
            speed = lowest;
        end else begin
            speed = 4'h0;                                  // [RULE_18]
        end
    end

endmodule

// File: test/msfs_props.sv
// concurrent checks on the ports of the select block
// assumes a bind onto msfs_top; one pclk domain, async presetn
`timescale 1ns/1ps

module msfs_props
    import msfs_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_DW-1:0] pwdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [FREQ_W-1:0] jog_freq,
    input wire logic              cur_valid,
    input wire logic [FREQ_W-1:0] cur_freq,
    input wire logic [FREQ_W-1:0] volt_freq,
    input wire logic [FREQ_W-1:0] freq_cmd,
    input wire msfs_src_t         freq_src,
    input wire logic              cmd_valid,
    input wire logic [3:0]        speed_sel,
    input wire logic              remote_up
);
    // =========================================
    // one domain: clock and reset named once
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_setup; psel && !penable; endsequence
    sequence s_big; psel && !penable && pwrite && paddr < 8'h0c && pwdata > 32'h0000_0fa0; endsequence
    sequence s_answer; pready ##1 !pready; endsequence

    // =========================================
    // bus answers
    property p_answer; s_setup |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("pready not one cycle");
    property p_range; s_big |=> pready && pslverr; endproperty
    a_range: assert property (p_range) else $error("out of range preset accepted");

    // =========================================
    // command sources; outputs lag inputs one edge
    property p_none; !cmd_valid |-> freq_cmd == '0 && freq_src == SRC_NONE; endproperty
    a_none: assert property (p_none) else $error("idle command not cleared");
    property p_jog; freq_src == SRC_JOG |-> freq_cmd == $past(jog_freq); endproperty
    a_jog: assert property (p_jog) else $error("jog frequency wrong");
    property p_cur; freq_src == SRC_CURRENT |-> freq_cmd == $past(cur_freq) && $past(cur_valid); endproperty
    a_cur: assert property (p_cur) else $error("current command wrong");
    property p_volt; freq_src == SRC_VOLTAGE |-> freq_cmd == $past(volt_freq) && !$past(cur_valid); endproperty
    a_volt: assert property (p_volt) else $error("voltage command beat current");
    property p_multi; freq_src == SRC_MULTI |-> speed_sel != 4'h0 && cmd_valid; endproperty
    a_multi: assert property (p_multi) else $error("multi command without speed");
    property p_notsel; freq_src == SRC_MULTI |-> freq_cmd != NOT_SEL; endproperty
    a_notsel: assert property (p_notsel) else $error("unselected preset used");
    // three cycles of remote level cover the lag of a remote write
    property p_remote; remote_up [*3] |-> freq_src != SRC_MULTI; endproperty
    a_remote: assert property (p_remote) else $error("multi speed active in remote");
endmodule

bind msfs_top msfs_props i_props (.*);

// File: test/msfs_contacts.sv
// contact switch model for the input terminals
// assumes closures are asked for just after a pclk edge
`timescale 1ns/1ps

module msfs_contacts #(
    parameter int NTERM = 5
)
(
    input  wire logic [NTERM-1:0] close_req,
    input  wire logic             pclk,
    output logic      [NTERM-1:0] term_in
);
    // =========================================
    // closures show one edge late, as a slow contact would
    always @(posedge pclk) begin
        term_in <= close_req;
    end
endmodule

// File: test/multi_speed_frequency_select_test.sv
// self-checking bench for the speed select block
// assumes the package, design, contact model and checker
`timescale 1ns/1ps

module multi_speed_frequency_select_test;
    import msfs_pkg::*;

    localparam logic [13:0] DFLT [3] = '{HIGH_RST, MID_RST, LOW_RST};
    logic        pclk;
    logic        presetn;
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [4:0]  close_req;
    logic [4:0]  term_in;
    logic [13:0] jog_freq;
    logic        cur_valid;
    logic [13:0] cur_freq;
    logic        volt_valid;
    logic [13:0] volt_freq;
    logic [13:0] freq_cmd;
    msfs_src_t   freq_src;
    logic        cmd_valid;
    logic [3:0]  speed_sel;
    logic        remote_up;
    logic        remote_down;
    logic        remote_clear;
    int          n_fail;
    int          check_count;

    msfs_top #(.NTERM(5)) i_dut (.*);
    msfs_contacts #(.NTERM(5)) i_contacts (.*);

    // =========================================
    // 40 MHz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // =========================================
    // reporting
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // =========================================
    // apb master; holds the request until pready at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        paddr <= a;
        pwrite <= wr;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            $display("ERROR %0t: no pready", $time);
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        er;
        apb(1'b1, a, d, r, er);
        chk(32'(er), 32'(e));
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic e);
        logic [31:0] r;
        logic        er;
        apb(1'b0, a, 32'h0, r, er);
        chk(r, x);
        chk(32'(er), 32'(e));
    endtask

    // closes contacts, waits out both register stages, judges
    task automatic look(input logic [4:0] sw, input msfs_src_t src, input logic [13:0] f, input logic [3:0] sp);
        close_req <= sw;
        repeat (4) @(posedge pclk);
        chk(32'(freq_src), 32'(src));
        chk(32'(freq_cmd), 32'(f));
        chk(32'(cmd_valid), 32'(src != SRC_NONE));
        if (src == SRC_MULTI) begin
            chk(32'(speed_sel), 32'(sp));
        end
    endtask

    // =========================================
    // scenarios
    task automatic t_reset();
        logic [3:0] tf [5] = '{FN_LOW, FN_MID, FN_HIGH, FN_JOG, FN_NONE};
        for (int n = 0; n < 15; n++) begin
            rd(8'(4 * n), n < 3 ? 32'(DFLT[n]) : 32'(NOT_SEL), 1'b0);
        end
        for (int i = 0; i < 5; i++) begin
            rd(8'(OFF_TERM + 4 * i), 32'(tf[i]), 1'b0);
        end
        rd(OFF_MODE, 32'h0, 1'b0);
        rd(OFF_REMOTE, 32'h0, 1'b0);
        rd(OFF_EXTDISP, 32'h0, 1'b0);
        rd(OFF_STATUS, 32'h0, 1'b0);
        rd(8'h64, 32'h0, 1'b1);
        wr(OFF_STATUS, 32'h1, 1'b1);
    endtask

    task automatic t_mode();
        logic [2:0] m [3] = '{3'h2, MODE_COMB, MODE_EXT};
        look(5'b00100, SRC_NONE, 14'h0, 4'h0);
        for (int i = 0; i < 3; i++) begin
            wr(OFF_MODE, 32'(m[i]), 1'b0);
            look(5'b00100, i > 0 ? SRC_MULTI : SRC_NONE, i > 0 ? HIGH_RST : 14'h0, 4'h1);
        end
    endtask

    task automatic t_fallback();
        look(5'b00110, SRC_MULTI, MID_RST, 4'h2);
        look(5'b00111, SRC_MULTI, LOW_RST, 4'h3);
        wr(OFF_TERM + 8'h10, 32'(FN_EXT), 1'b0);
        look(5'b10000, SRC_MULTI, LOW_RST, 4'h3);
    endtask

    task automatic t_range();
        wr(8'h00, 32'h0fa1, 1'b1);
        wr(8'h00, 32'h0fa0, 1'b0);
        rd(8'h00, 32'h0fa0, 1'b0);
        wr(8'h00, 32'(NOT_SEL), 1'b1);
        wr(8'h0c, 32'h0fa1, 1'b1);
        wr(8'h0c, 32'(NOT_SEL), 1'b0);
        wr(8'h00, 32'(HIGH_RST), 1'b0);
    endtask

    task automatic t_decode();
        logic [3:0]  tbl [8] = '{4'h0, 4'h3, 4'h2, 4'h4, 4'h1, 4'h5, 4'h6, 4'h7};
        logic [3:0]  sp;
        logic [13:0] f;
        for (int s = 4; s < 16; s++) begin
            wr(8'(4 * (s - 1)), 32'(s * 16), 1'b0);
        end
        for (int i = 1; i < 16; i++) begin
            sp = i[3] ? 4'(8 + i[2:0]) : tbl[i[2:0]];
            f = sp > 3 ? 14'(sp * 16) : DFLT[sp - 1];
            look(5'({i[3], 1'b0, i[2:0]}), SRC_MULTI, f, sp);
        end
    endtask

    task automatic t_prio();
        cur_valid <= 1'b1;
        volt_valid <= 1'b1;
        look(5'b01100, SRC_JOG, jog_freq, 4'h0);
        look(5'b00100, SRC_MULTI, HIGH_RST, 4'h1);
        look(5'b00000, SRC_CURRENT, cur_freq, 4'h0);
        cur_valid <= 1'b0;
        look(5'b00000, SRC_VOLTAGE, volt_freq, 4'h0);
        volt_valid <= 1'b0;
        look(5'b00000, SRC_NONE, 14'h0, 4'h0);
    endtask

    task automatic t_remote();
        for (int r = 1; r < 4; r++) begin
            wr(OFF_REMOTE, 32'(r), 1'b0);
            for (int k = 0; k < 3; k++) begin
                look(5'(1 << k), SRC_NONE, 14'h0, 4'h0);
                chk(32'({remote_up, remote_down, remote_clear}), 32'({k == 2, k == 1, k == 0}));
            end
        end
        wr(OFF_REMOTE, 32'h0, 1'b0);
    endtask

    task automatic t_route();
        wr(OFF_TERM, 32'(FN_HIGH), 1'b0);
        look(5'b00001, SRC_MULTI, HIGH_RST, 4'h1);
        wr(OFF_TERM, 32'(FN_MID), 1'b0);
        look(5'b00001, SRC_MULTI, MID_RST, 4'h2);
        wr(OFF_TERM, 32'(FN_LOW), 1'b0);
    endtask

    task automatic t_lock();
        look(5'b00100, SRC_MULTI, HIGH_RST, 4'h1);
        wr(OFF_EXTDISP, 32'h1, 1'b0);
        wr(8'h10, 32'h0021, 1'b1);
        rd(8'h10, 32'h0050, 1'b0);
        wr(8'h00, 32'h0190, 1'b0);
        look(5'b00100, SRC_MULTI, 14'h0190, 4'h1);
        wr(OFF_EXTDISP, 32'h0, 1'b0);
        wr(8'h10, 32'h0021, 1'b0);
        wr(OFF_MODE, 32'h1, 1'b0);
        wr(8'h04, 32'h0190, 1'b0);
    endtask

    // =========================================
    // main sequence
    initial begin
        presetn = 1'b0;
        paddr = 8'h0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        close_req = 5'h0;
        jog_freq = 14'h0032;
        cur_valid = 1'b0;
        cur_freq = 14'h0123;
        volt_valid = 1'b0;
        volt_freq = 14'h0234;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_mode();
        t_fallback();
        t_range();
        t_decode();
        t_prio();
        t_remote();
        t_route();
        t_lock();
        print_verdict();
    end
endmodule
